// ===== inc/dbx_regs.vh
`ifndef DBX_REGS_VH
`define DBX_REGS_VH
`define DBX_IDX_W        3
`define DBX_IDX_STATUS   3'h6
`define DBX_IDX_CONTROL  3'h7
`define DBX_ST_SSTEP     4'he
`define DBX_ST_TSWITCH   4'hf
`define DBX_ST_DETECT    4'hd
`define DBX_CT_DETECT_EN 4'hd
`define DBX_CT_TYPE_LO   5'h10
`define DBX_AT_EXEC      2'h0
`define DBX_AT_WRITE     2'h1
`define DBX_AT_IO        2'h2
`define DBX_AT_RDWR      2'h3
`define DBX_LEN_1        2'h0
`define DBX_LEN_2        2'h1
`define DBX_LEN_8        2'h2
`define DBX_LEN_4        2'h3
`define DBX_VEC_DEBUG    8'h01
`define DBX_VEC_BRKINSN  8'h03
`define DBX_STATUS_RST   64'h0000_0000_ffff_0ff0
`define DBX_CONTROL_RST  64'h0000_0000_0000_0400
`endif

// ===== rtl/dbx_bp_match.v
`include "dbx_regs.vh"
`default_nettype none
// One breakpoint comparator; length masks low address bits
module dbx_bp_match (
  input  wire [63:0] bp_addr_in,
  input  wire [1:0]  match_length_in,
  input  wire [63:0] acc_addr_in,
  input  wire [3:0]  acc_len_in,
  output reg         hit_out
);
  reg [63:0] mask;
  reg [63:0] acc_last;
  reg [63:0] bp_lo;
  reg [63:0] bp_hi;
  always @* begin
    case (match_length_in) // see RQ23
      `DBX_LEN_1: mask = 64'hffff_ffff_ffff_ffff;
      `DBX_LEN_2: mask = 64'hffff_ffff_ffff_fffe;
      `DBX_LEN_8: mask = 64'hffff_ffff_ffff_fff8; // see RQ6
      default:    mask = 64'hffff_ffff_ffff_fffc;
    endcase
    bp_lo = bp_addr_in & mask;
    bp_hi = bp_lo | ~mask;
    acc_last = acc_addr_in + {60'h0, acc_len_in} - 64'h1;
    // Any byte of the access inside the range
    hit_out = (acc_len_in != 4'h0) && (acc_addr_in <= bp_hi) &&
              (acc_last >= bp_lo);
  end
endmodule
`default_nettype wire

// ===== rtl/dbx_debug_unit.v
// Summary of operation
// RQ1: Narrow writes zero upper 32 bits.
// RQ2: Narrow reads return lower 32 bits.
// RQ3: Wide mode moves full 64 bits.
// RQ4: Upper status/control ones raise protection fault.
// RQ5: Breakpoint addresses fully writable, unchecked.
// RQ6: Eight-byte data length works everywhere.
// RQ7: Debug vector 1, breakpoint instruction 3.
// RQ8: Instruction and detect are faults; rest traps.
// RQ9: Set matching status flag per condition.
// RQ10: Access type selects execute/write/io/readwrite.
// RQ11: One exception records all flags.
// RQ12: Execute breakpoint faults before the instruction.
// RQ13: Instruction breakpoints win over everything.
// RQ14: Stack segment load suppresses next breakpoint; code masks execute breakpoints only.
// RQ15: Resume flag masks instruction breakpoints.
// RQ16: Resume flag cleared at instruction start.
// RQ17: Task switch, wide return restore resume.
// RQ18: Other faults push resume flag one.
// RQ19: Mid-string interrupts and traps push one.
// RQ20: Otherwise push current resume flag.
// RQ21: Resume flag never masks data breakpoints.
// RQ22: Detect enable traps register access, cleared.
// RQ23: Length field picks 1,2,4,8 bytes.
// RQ24: Hit flags stay until software clears.
`include "dbx_regs.vh"
`default_nettype none
module dbx_debug_unit (
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire        wide_mode_in,
  input  wire        reg_move_in,
  input  wire        reg_write_in,
  input  wire [2:0]  reg_idx_in,
  input  wire [63:0] reg_wdata_in,
  input  wire        insn_start_in,
  input  wire [63:0] insn_addr_in,
  input  wire        stack_segment_load_in,
  input  wire        data_acc_in,
  input  wire        data_write_in,
  input  wire        io_acc_in,
  input  wire [63:0] acc_addr_in,
  input  wire [3:0]  acc_len_in,
  input  wire        insn_done_in,
  input  wire        trap_flag_in,
  input  wire        task_switch_trap_in,
  input  wire        resume_load_in,
  input  wire        resume_image_in,
  input  wire        event_in,
  input  wire        event_fault_in,
  input  wire        event_mid_string_in,
  input  wire        brk_insn_in,
  output reg  [63:0] reg_rdata_out,
  output reg         reg_rvalid_out,
  output reg         protection_fault_zero_out,
  output reg         debug_fault_out,
  output reg         debug_trap_out,
  output reg  [7:0]  vector_out,
  output reg         pushed_resume_out,
  output reg         pushed_valid_out,
  output reg         resume_flag_out,
  output reg  [63:0] debug_status_out,
  output reg  [63:0] debug_control_out
);
  reg [63:0] bp_addr [0:3];
  reg [63:0] debug_status_reg;
  reg [63:0] debug_control_reg;
  reg        resume_flag;
  reg        ss_inhibit;
  wire [3:0] data_hit;
  wire [3:0] exec_hit;
  reg [3:0]  trap_hits;
  reg [63:0] wval;
  reg [63:0] rval;
  reg        bad_upper;
  reg        detect_fault;
  reg        exec_fault;
  reg        trap_any;
  reg [63:0] next_status;
  wire [3:0] cmp_hit;
  wire       detect_en;
  integer    k;

  reg [2:0]  cause;
  reg [63:0] next_rdata;
  reg        next_rvalid;
  reg        next_prot_fault;
  reg        next_fault;
  reg        next_trap;
  reg [7:0]  next_vector;
  reg        next_push_valid;
  reg        next_push_resume;
  reg [63:0] next_control;
  reg [63:0] next_status_wr;
  reg        next_resume;
  reg        next_ss_inhibit;
  reg        bp_wr_en;
  reg [1:0]  bp_wr_idx;

  localparam [2:0] CAUSE_NONE   = 3'h0;
  localparam [2:0] CAUSE_EXEC   = 3'h1;
  localparam [2:0] CAUSE_DETECT = 3'h2;
  localparam [2:0] CAUSE_PROT   = 3'h3;
  localparam [2:0] CAUSE_MOVE   = 3'h4;
  localparam [2:0] CAUSE_TRAP   = 3'h5;
  localparam [2:0] CAUSE_BRK    = 3'h6;
  localparam [2:0] CAUSE_EVENT  = 3'h7;

  assign detect_en = debug_control_reg[`DBX_CT_DETECT_EN];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_bp
      wire [1:0] atype;
      wire [1:0] alen;
      wire       en;
      wire [63:0] caddr;
      wire [3:0]  clen;
      assign atype = debug_control_reg[16+4*g +: 2];
      assign alen  = debug_control_reg[18+4*g +: 2];
      assign en    = debug_control_reg[2*g] | debug_control_reg[2*g+1];
      // Execute compare uses a one-byte fetch at the insn start
      assign caddr = (atype == `DBX_AT_EXEC) ? insn_addr_in : acc_addr_in;
      assign clen  = (atype == `DBX_AT_EXEC) ? 4'h1 : acc_len_in;
      dbx_bp_match u_match (
        .bp_addr_in      (bp_addr[g]),
        .match_length_in (alen),
        .acc_addr_in     (caddr),
        .acc_len_in      (clen),
        .hit_out         (cmp_hit[g])
      );
      assign exec_hit[g] = en && cmp_hit[g] && insn_start_in &&
                           atype == `DBX_AT_EXEC; // see RQ10
      // Data hits ignore the resume flag on purpose
      assign data_hit[g] = en && cmp_hit[g] && ( // see RQ10 see RQ21
        (atype == `DBX_AT_WRITE && data_acc_in && data_write_in) ||
        (atype == `DBX_AT_IO && io_acc_in) ||
        (atype == `DBX_AT_RDWR && data_acc_in));
    end
  endgenerate

  always @* begin
    // Narrow writes keep only the low word
    wval = wide_mode_in ? reg_wdata_in
                        : {32'h0, reg_wdata_in[31:0]}; // see RQ1 see RQ3
    if (reg_idx_in == `DBX_IDX_STATUS) begin
      rval = debug_status_reg;
    end else if (reg_idx_in == `DBX_IDX_CONTROL) begin
      rval = debug_control_reg;
    end else if (reg_idx_in[2] == 1'b0) begin
      rval = bp_addr[reg_idx_in[1:0]];
    end else begin
      rval = 64'h0;
    end
    if (!wide_mode_in) begin
      rval = {32'h0, rval[31:0]}; // see RQ2
    end
    bad_upper = reg_move_in && reg_write_in && wide_mode_in &&
                (reg_idx_in == `DBX_IDX_STATUS ||
                 reg_idx_in == `DBX_IDX_CONTROL) &&
                (reg_wdata_in[63:32] != 32'h0); // see RQ4
    detect_fault = reg_move_in && detect_en; // see RQ22
    // Blocked by resume flag and stack segment load shadow
    exec_fault = (|exec_hit) && !resume_flag &&
                 !ss_inhibit; // see RQ15 see RQ14
    trap_hits = insn_done_in ? data_hit : 4'h0;
    trap_any = (|trap_hits) || (insn_done_in && trap_flag_in) ||
               task_switch_trap_in; // see RQ8
    next_status = debug_status_reg;
    // Flags accumulate; only software clears them
    if (exec_fault) begin // see RQ13
      next_status[3:0] = next_status[3:0] | exec_hit; // see RQ9
    end else if (detect_fault) begin
      next_status[`DBX_ST_DETECT] = 1'b1; // see RQ9
    end else begin
      next_status[3:0] = next_status[3:0] | trap_hits; // see RQ11
      if (insn_done_in && trap_flag_in) begin
        next_status[`DBX_ST_SSTEP] = 1'b1;
      end
      if (task_switch_trap_in) begin
        next_status[`DBX_ST_TSWITCH] = 1'b1;
      end
    end
  end

  // Priority order picks the one request serviced this cycle
  always @* begin
    if (exec_fault) begin // see RQ13
      cause = CAUSE_EXEC;
    end else if (detect_fault) begin
      cause = CAUSE_DETECT;
    end else if (bad_upper) begin
      cause = CAUSE_PROT;
    end else if (reg_move_in) begin
      cause = CAUSE_MOVE;
    end else if (trap_any) begin
      cause = CAUSE_TRAP;
    end else if (brk_insn_in) begin
      cause = CAUSE_BRK;
    end else if (event_in) begin
      cause = CAUSE_EVENT;
    end else begin
      cause = CAUSE_NONE;
    end
  end

  // Lower requests in the same cycle are dropped, not queued
  always @* begin
    next_rdata       = reg_rdata_out;
    next_rvalid      = 1'b0;
    next_prot_fault  = 1'b0;
    next_fault       = 1'b0;
    next_trap        = 1'b0;
    next_vector      = vector_out;
    next_push_valid  = 1'b0;
    next_push_resume = pushed_resume_out;
    next_control     = debug_control_reg;
    next_status_wr   = next_status;
    bp_wr_en         = 1'b0;
    bp_wr_idx        = reg_idx_in[1:0];
    case (cause)
      CAUSE_EXEC: begin
        next_fault       = 1'b1; // see RQ12
        next_vector      = `DBX_VEC_DEBUG; // see RQ7
        next_push_valid  = 1'b1;
        // Breakpoint fault keeps live resume value
        next_push_resume = resume_flag; // see RQ20
        next_control[`DBX_CT_DETECT_EN] = 1'b0; // see RQ22
      end
      CAUSE_DETECT: begin
        next_fault       = 1'b1;
        next_vector      = `DBX_VEC_DEBUG;
        next_push_valid  = 1'b1;
        next_push_resume = 1'b1; // see RQ18
        next_control[`DBX_CT_DETECT_EN] = 1'b0; // see RQ22
      end
      CAUSE_PROT: begin
        // Refused move: no register changes
        next_prot_fault  = 1'b1; // see RQ4
        next_push_valid  = 1'b1;
        next_push_resume = 1'b1; // see RQ18
      end
      CAUSE_MOVE: begin
        if (!reg_write_in) begin
          next_rdata  = rval;
          next_rvalid = 1'b1;
        end else if (reg_idx_in == `DBX_IDX_STATUS) begin
          // Hardware sets in the same cycle win over the write
          next_status_wr = wval | (next_status & ~debug_status_reg);
        end else if (reg_idx_in == `DBX_IDX_CONTROL) begin
          next_control = wval;
        end else if (reg_idx_in[2] == 1'b0) begin
          bp_wr_en = 1'b1; // see RQ5
        end
      end
      CAUSE_TRAP: begin
        next_trap        = 1'b1; // see RQ8
        next_vector      = `DBX_VEC_DEBUG;
        next_push_valid  = 1'b1;
        next_push_resume = event_mid_string_in | resume_flag; // see RQ19
        next_control[`DBX_CT_DETECT_EN] = 1'b0;
      end
      CAUSE_BRK: begin
        // Software interrupt: resume flag already clear
        next_vector      = `DBX_VEC_BRKINSN; // see RQ7
        next_push_valid  = 1'b1;
        next_push_resume = 1'b0; // see RQ20
      end
      CAUSE_EVENT: begin
        // Plain handler entry: no debug flag
        next_push_valid  = 1'b1;
        next_push_resume = event_fault_in | event_mid_string_in |
                           resume_flag; // see RQ18 see RQ19 see RQ20
      end
      default: begin
        next_push_valid = 1'b0;
      end
    endcase
  end

  always @* begin
    // Load wins over clear: restore lands after the start
    if (resume_load_in) begin
      next_resume = resume_image_in; // see RQ17
    end else if (insn_start_in) begin
      next_resume = 1'b0; // see RQ16
    end else begin
      next_resume = resume_flag;
    end
    // Shadow covers only the next instruction start
    if (insn_start_in) begin
      next_ss_inhibit = stack_segment_load_in;
    end else begin
      next_ss_inhibit = ss_inhibit;
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (k = 0; k < 4; k = k + 1) begin
        bp_addr[k] <= 64'h0;
      end
      debug_status_reg          <= `DBX_STATUS_RST;
      debug_control_reg         <= `DBX_CONTROL_RST;
      resume_flag               <= 1'b0;
      ss_inhibit                <= 1'b0;
      reg_rdata_out             <= 64'h0;
      reg_rvalid_out            <= 1'b0;
      protection_fault_zero_out <= 1'b0;
      debug_fault_out           <= 1'b0;
      debug_trap_out            <= 1'b0;
      vector_out                <= 8'h0;
      pushed_resume_out         <= 1'b0;
      pushed_valid_out          <= 1'b0;
    end else begin
      reg_rdata_out             <= next_rdata;
      reg_rvalid_out            <= next_rvalid;
      protection_fault_zero_out <= next_prot_fault;
      debug_fault_out           <= next_fault;
      debug_trap_out            <= next_trap;
      vector_out                <= next_vector;
      pushed_valid_out          <= next_push_valid;
      pushed_resume_out         <= next_push_resume;
      debug_status_reg          <= next_status_wr; // see RQ24
      debug_control_reg         <= next_control;
      resume_flag               <= next_resume;
      ss_inhibit                <= next_ss_inhibit;
      if (bp_wr_en) begin
        bp_addr[bp_wr_idx] <= wval; // see RQ5
      end
    end
  end

  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      resume_flag_out   <= 1'b0;
      debug_status_out  <= `DBX_STATUS_RST;
      debug_control_out <= `DBX_CONTROL_RST;
    end else begin
      resume_flag_out   <= resume_flag;
      debug_status_out  <= debug_status_reg;
      debug_control_out <= debug_control_reg;
    end
  end
endmodule
`default_nettype wire

// ===== dv/dbx_debug_unit_checker.sv
`default_nettype none
module dbx_debug_unit_checker (
  input wire logic        mclk_in, rst_n_in, wide_mode_in, reg_move_in,
  input wire logic        reg_write_in, insn_start_in, insn_done_in,
  input wire logic        trap_flag_in, task_switch_trap_in, event_in,
  input wire logic        resume_load_in, resume_image_in, event_fault_in,
  input wire logic        brk_insn_in, reg_rvalid_out, debug_trap_out,
  input wire logic        protection_fault_zero_out, debug_fault_out,
  input wire logic        pushed_resume_out, pushed_valid_out,
  input wire logic        resume_flag_out,
  input wire logic [2:0]  reg_idx_in,
  input wire logic [7:0]  vector_out,
  input wire logic [63:0] reg_wdata_in, reg_rdata_out, debug_status_out,
  input wire logic [63:0] debug_control_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Higher-priority requests that would preempt the low ones
  wire q = !(insn_start_in | reg_move_in | task_switch_trap_in);
  sequence trap_then_flag;
    debug_trap_out ##1 debug_status_out[14];
  endsequence
  narrow_read_a: assert property (reg_rvalid_out
    && !$past(wide_mode_in) |-> reg_rdata_out[63:32] == 32'h0)
    else $error("narrow read upper");
  read_cause_a: assert property (reg_rvalid_out
    |-> $past(reg_move_in && !reg_write_in)) else $error("stray rvalid");
  prot_fault_a: assert property (protection_fault_zero_out |->
    $past(reg_move_in && reg_write_in && wide_mode_in &&
    reg_idx_in[2:1] == 2'b11 && |reg_wdata_in[63:32]))
    else $error("stray protection fault");
  ctl_upper_a: assert property (debug_control_out[63:32] == 32'h0)
    else $error("control upper set");
  debug_vec_a: assert property (debug_fault_out || debug_trap_out
    |-> vector_out == 8'h01) else $error("debug vector");
  brk_vec_a: assert property (brk_insn_in && q && !insn_done_in
    |=> vector_out == 8'h03) else $error("break vector");
  step_trap_a: assert property (insn_done_in && trap_flag_in && q
    && !brk_insn_in |=> trap_then_flag) else $error("single step");
  fault_push_a: assert property (event_in && event_fault_in && q
    && !insn_done_in && !brk_insn_in |=> pushed_valid_out &&
    pushed_resume_out) else $error("fault push");
  resume_load_a: assert property (resume_load_in |=> ##1
    resume_flag_out == $past(resume_image_in, 2)) else $error("rf load");
  hit_sticky_a: assert property (|(~debug_status_out &
    $past(debug_status_out) & 64'he00f) |->
    $past(reg_move_in && reg_write_in, 2)) else $error("hit lost");
endmodule
bind dbx_debug_unit dbx_debug_unit_checker u_chk (.mclk_in, .rst_n_in,
  .wide_mode_in, .reg_move_in, .reg_write_in, .insn_start_in, .insn_done_in,
  .trap_flag_in, .task_switch_trap_in, .event_in, .resume_load_in,
  .resume_image_in, .event_fault_in, .brk_insn_in, .reg_rvalid_out,
  .debug_trap_out, .protection_fault_zero_out, .debug_fault_out,
  .pushed_resume_out, .pushed_valid_out, .resume_flag_out, .reg_idx_in,
  .vector_out, .reg_wdata_in, .reg_rdata_out, .debug_status_out,
  .debug_control_out);
`default_nettype wire

// ===== dv/dbx_debug_unit_tb.sv
`include "dbx_regs.vh"
`default_nettype none
module dbx_debug_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 0, rst_n_in = 0, wide_mode_in, reg_move_in;
  logic        reg_write_in, insn_start_in, stack_segment_load_in;
  logic        data_acc_in, data_write_in, io_acc_in, insn_done_in;
  logic        trap_flag_in, task_switch_trap_in, resume_load_in;
  logic        resume_image_in, event_in, event_fault_in;
  logic        event_mid_string_in, brk_insn_in;
  logic [2:0]  reg_idx_in;
  logic [3:0]  acc_len_in;
  logic [63:0] reg_wdata_in, insn_addr_in, acc_addr_in, a, s;
  logic [63:0] reg_rdata_out, debug_status_out, debug_control_out;
  logic [7:0]  vector_out;
  logic        reg_rvalid_out, protection_fault_zero_out, debug_fault_out;
  logic        debug_trap_out, pushed_resume_out, pushed_valid_out;
  logic        resume_flag_out;
  int          err_count = 0, n_checks = 0;
  always #2 mclk_in = ~mclk_in;
  dbx_debug_unit DUT (.mclk_in, .rst_n_in, .wide_mode_in, .reg_move_in,
    .reg_write_in, .reg_idx_in, .reg_wdata_in, .insn_start_in,
    .insn_addr_in, .stack_segment_load_in, .data_acc_in, .data_write_in,
    .io_acc_in, .acc_addr_in, .acc_len_in, .insn_done_in, .trap_flag_in,
    .task_switch_trap_in, .resume_load_in, .resume_image_in, .event_in,
    .event_fault_in, .event_mid_string_in, .brk_insn_in, .reg_rdata_out,
    .reg_rvalid_out, .protection_fault_zero_out, .debug_fault_out,
    .debug_trap_out, .vector_out, .pushed_resume_out, .pushed_valid_out,
    .resume_flag_out, .debug_status_out, .debug_control_out);
  task automatic idle;
    {reg_move_in, reg_write_in, insn_start_in, data_acc_in, data_write_in,
     io_acc_in, insn_done_in, trap_flag_in, task_switch_trap_in,
     resume_load_in, event_in, event_fault_in, event_mid_string_in,
     brk_insn_in} <= '0;
  endtask
  // Request taken at this edge; pulses settle 1ns later
  task automatic stb;
    @(posedge mclk_in);
    idle;
    #1;
  endtask
  task automatic wt;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic ck(string s, logic [63:0] e, logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic mv(logic w, logic [2:0] i, logic [63:0] d, logic wd);
    @(posedge mclk_in);
    {reg_move_in, reg_write_in, reg_idx_in, reg_wdata_in, wide_mode_in}
      <= {1'b1, w, i, d, wd};
    stb;
  endtask
  task automatic start(logic [63:0] x);
    @(posedge mclk_in);
    {insn_start_in, insn_addr_in} <= {1'b1, x};
    stb;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    print_verdict;
  end
  initial begin
    a = $urandom(32'h3925c88e);
    idle;
    {wide_mode_in, reg_idx_in, reg_wdata_in, insn_addr_in, acc_addr_in,
     acc_len_in, stack_segment_load_in, resume_image_in} <= '0;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1;
    wt;
    ck("status rst", `DBX_STATUS_RST, debug_status_out);
    ck("control rst", `DBX_CONTROL_RST, debug_control_out);
    for (int w = 0; w < 2; w++) begin
      a = {$urandom, $urandom};
      mv(1, 3'(w), a, w[0]);
      mv(0, 3'(w), 0, 1);
      ck("rdata", w ? a : {32'h0, a[31:0]}, reg_rdata_out);
    end
    mv(0, 1, 0, 0);
    ck("narrow rd", {32'h0, a[31:0]}, reg_rdata_out);
    mv(1, 7, {$urandom | 32'h1, 32'h0}, 1);
    ck("prot", 1, protection_fault_zero_out);
    wt;
    ck("ctl kept", `DBX_CONTROL_RST, debug_control_out);
    mv(1, 0, a, 1);
    mv(1, 7, 64'h2, 1);
    mv(1, 6, 64'h0, 1);
    start(a);
    ck("exec", 3'b110, {debug_fault_out, pushed_valid_out,
      pushed_resume_out});
    wt;
    ck("b0 hit", 1, debug_status_out[0]);
    @(posedge mclk_in);
    {resume_load_in, resume_image_in} <= 2'b11;
    stb;
    start(a);
    ck("rf mask", 0, debug_fault_out);
    ck("rf out", 1, resume_flag_out);
    start(a);
    ck("rf clr", 1, debug_fault_out);
    for (int n = 1; n < 4; n++) begin
      a = {$urandom, $urandom} & ~64'h7;
      mv(1, 3'(n), a, 1);
      mv(1, 7, (64'h1 << 2*n) | (64'(n) << 16+4*n) | (64'h2 << 18+4*n), 1);
      mv(1, 6, 0, 1);
      @(posedge mclk_in);
      // Resume flag set too: data hits must still fire
      {data_acc_in, data_write_in, io_acc_in, insn_done_in, trap_flag_in,
       resume_load_in, resume_image_in, acc_addr_in, acc_len_in}
        <= {n != 2, n == 1, n == 2, 2'b11, 2'b11, a + 64'h5, 4'h1};
      stb;
      ck("trap", 1, debug_trap_out);
      wt;
      s = debug_status_out & 64'h400f;
      ck("hits", 64'h4000 | 64'h1 << n, s);
    end
    mv(1, 7, 64'h2000, 1);
    mv(0, 0, 0, 1);
    ck("gd", 2'b10, {debug_fault_out, reg_rvalid_out});
    wt;
    s = {debug_status_out[13], debug_control_out[13]};
    ck("gd flags", 2'b10, s);
    // Clear the resume flag so the push checks below can trip
    start(a);
    @(posedge mclk_in);
    {event_in, event_fault_in} <= 2'b11;
    stb;
    ck("flt push", 2'b11, {pushed_valid_out, pushed_resume_out});
    @(posedge mclk_in);
    {event_in, event_mid_string_in} <= 2'b11;
    stb;
    ck("str push", 2'b11, {pushed_valid_out, pushed_resume_out});
    @(posedge mclk_in);
    event_in <= 1;
    stb;
    ck("bare push", 2'b10, {pushed_valid_out, pushed_resume_out});
    mv(1, 0, a, 1);
    mv(1, 7, 64'h2001, 1);
    @(posedge mclk_in);
    {insn_start_in, insn_addr_in, stack_segment_load_in} <= {1'b1, ~a, 1'b1};
    stb;
    stack_segment_load_in <= 0;
    start(a);
    ck("ss shadow", 0, debug_fault_out);
    start(a);
    ck("exec again", 1, debug_fault_out);
    wt;
    ck("gd on exec", 0, debug_control_out[13]);
    @(posedge mclk_in);
    brk_insn_in <= 1;
    stb;
    ck("brk vec", 8'h03, vector_out);
    @(posedge mclk_in);
    task_switch_trap_in <= 1;
    stb;
    wt;
    ck("tswitch", 1, debug_status_out[15]);
    print_verdict;
  end
endmodule
`default_nettype wire
